// ---- cfs_status_bank.sv ----
// card-mode base words and function status window register bank
//
// Behaviour
// - card-mode layout only while select pin high
// - two base words, same status window
// - base low byte zero, upper bits writable
// - event register at zero, bits 4,15
// - bits 0 to 3 read zero
// - mask register at 4, bits 4,14,15
// - mask bits 5 and 6 read zero
// - reset status at 8, bits 4,15
// - reserved bit ranges read zero
`timescale 1ns/10ps
module cfs_status_bank (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                cardModeIn,
   input  wire cfs_pkg::cfs_access_type accessIn,
   input  wire logic                wakeEventIn,
   input  wire logic                intEventIn,
   output cfs_pkg::cfs_answer_type  answer_r,
   output logic                     wakeReq_r,
   output logic                     intReq_r
);
   import cfs_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic           cardMode;        // synchronised select level
   logic [23:0]    baseFirst_r;     // first base, bits 31-8
   logic [23:0]    baseFirst_nxt;
   logic [23:0]    baseSecond_r;    // second base, bits 31-8
   logic [23:0]    baseSecond_nxt;
   logic [31:0]    event_r;         // event register storage
   logic [31:0]    event_nxt;
   logic [31:0]    evMask_r;        // event mask storage
   logic [31:0]    evMask_nxt;
   logic [31:0]    rstStat_r;       // reset status storage
   logic [31:0]    rstStat_nxt;
   cfs_answer_type answer_nxt;
   logic           wakeReq_nxt;
   logic           intReq_nxt;
   logic           winFirst;        // address inside first window
   logic           winSecond;       // address inside second window
   logic           winHit;          // memory access claimed
   logic           cfgFirst;        // config access to first base
   logic           cfgSecond;       // config access to second base
   logic [7:0]     winOff;          // offset inside window
   logic [31:0]    byteMask;        // byte enables spread to bits
   logic [31:0]    rdValue;         // read mux result
   logic           rdHit;           // read mux claimed

   // ----------------------------------------------------------------
   // select pin synchroniser
   // ----------------------------------------------------------------
   cfs_sync2 u_modeSync (
      .clk     (clk),
      .rst     (rst),
      .asyncIn (cardModeIn),
      .syncOut (cardMode)
   );

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------

   // spread byte enables to a bit mask
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         byteMask[i*8 +: 8] = {8{accessIn.be[i]}};
      end
   end

   // window and configuration matches
   always_comb begin
      winOff = accessIn.addr[BASE_LOW_BITS-1:0];
      winFirst  = cardMode && !accessIn.isCfg
                  && (baseFirst_r != BASE_RESET_VAL)
                  && (accessIn.addr[31:BASE_LOW_BITS] == baseFirst_r);
      winSecond = cardMode && !accessIn.isCfg
                  && (baseSecond_r != BASE_RESET_VAL)
                  && (accessIn.addr[31:BASE_LOW_BITS] == baseSecond_r);
      winHit    = winFirst || winSecond;
      cfgFirst  = cardMode && accessIn.isCfg
                  && (accessIn.addr[7:0] == CFG_BASE_FIRST_OFF);
      cfgSecond = cardMode && accessIn.isCfg
                  && (accessIn.addr[7:0] == CFG_BASE_SECOND_OFF);
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------

   // read multiplexer, unused bits forced to zero
   always_comb begin
      rdValue = 32'h0000_0000;
      rdHit   = 1'b0;
      if (cfgFirst) begin
         rdValue = {baseFirst_r, {BASE_LOW_BITS{1'b0}}};
         rdHit   = 1'b1;
      end else if (cfgSecond) begin
         rdValue = {baseSecond_r, {BASE_LOW_BITS{1'b0}}};
         rdHit   = 1'b1;
      end else if (winHit && winOff == WIN_EVENT_OFF) begin
         rdValue = event_r & EVENT_RD_MASK;
         rdHit   = 1'b1;
      end else if (winHit && winOff == WIN_EVENT_MASK_OFF) begin
         rdValue = evMask_r & MASK_RD_MASK;
         rdHit   = 1'b1;
      end else if (winHit && winOff == WIN_RESET_STAT_OFF) begin
         rdValue = rstStat_r & RESET_RD_MASK;
         rdHit   = 1'b1;
      end else if (winHit) begin
         // unused window word reads zero but is claimed
         rdValue = 32'h0000_0000;
         rdHit   = 1'b1;
      end
   end

   // answer registered one cycle after the strobe
   always_comb begin
      answer_nxt.valid = accessIn.rd || accessIn.wr;
      answer_nxt.hit   = (accessIn.rd || accessIn.wr) && rdHit;
      answer_nxt.rdata = accessIn.rd ? rdValue : 32'h0000_0000;
   end

   // ----------------------------------------------------------------
   // base word writes
   // ----------------------------------------------------------------

   // upper bits take write data under byte enables
   always_comb begin
      baseFirst_nxt  = baseFirst_r;
      baseSecond_nxt = baseSecond_r;
      if (accessIn.wr && cfgFirst) begin
         baseFirst_nxt = (baseFirst_r & ~byteMask[31:BASE_LOW_BITS])
                       | (accessIn.wdata[31:BASE_LOW_BITS]
                          & byteMask[31:BASE_LOW_BITS]);
      end
      if (accessIn.wr && cfgSecond) begin
         baseSecond_nxt = (baseSecond_r & ~byteMask[31:BASE_LOW_BITS])
                        | (accessIn.wdata[31:BASE_LOW_BITS]
                           & byteMask[31:BASE_LOW_BITS]);
      end
   end

   // ----------------------------------------------------------------
   // status register writes and event capture
   // ----------------------------------------------------------------

   // event bits: write one clears, hardware set wins
   always_comb begin
      event_nxt = event_r;
      if (accessIn.wr && winHit && winOff == WIN_EVENT_OFF) begin
         event_nxt = event_r
                   & ~(accessIn.wdata & byteMask & EVENT_RD_MASK);
      end
      // set beats a clear in the same cycle
      if (wakeEventIn) begin
         event_nxt[BIT_GEN_WAKE] = 1'b1;
      end
      if (intEventIn) begin
         event_nxt[BIT_INTR] = 1'b1;
      end
   end

   // mask and reset status: plain storage of writable bits
   always_comb begin
      evMask_nxt  = evMask_r;
      rstStat_nxt = rstStat_r;
      if (accessIn.wr && winHit && winOff == WIN_EVENT_MASK_OFF) begin
         evMask_nxt = (evMask_r & ~(byteMask & MASK_RD_MASK))
                    | (accessIn.wdata & byteMask & MASK_RD_MASK);
      end
      if (accessIn.wr && winHit && winOff == WIN_RESET_STAT_OFF) begin
         rstStat_nxt = (rstStat_r & ~(byteMask & RESET_RD_MASK))
                     | (accessIn.wdata & byteMask & RESET_RD_MASK);
      end
   end

   // ----------------------------------------------------------------
   // wake-up and interrupt requests
   // ----------------------------------------------------------------

   // requests follow event gated by its mask bit, wake also by mask bit 14
   always_comb begin
      wakeReq_nxt = cardMode && event_r[BIT_GEN_WAKE]
                    && evMask_r[BIT_GEN_WAKE]
                    && evMask_r[BIT_WAKE_MASK];
      intReq_nxt  = cardMode && event_r[BIT_INTR] && evMask_r[BIT_INTR];
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------

   // register all next values
   always_ff @(posedge clk) begin
      if (rst) begin
         baseFirst_r  <= BASE_RESET_VAL;
         baseSecond_r <= BASE_RESET_VAL;
         event_r      <= STAT_RESET_VAL;
         evMask_r     <= STAT_RESET_VAL;
         rstStat_r    <= STAT_RESET_VAL;
         answer_r     <= '0;
         wakeReq_r    <= 1'b0;
         intReq_r     <= 1'b0;
      end else begin
         baseFirst_r  <= baseFirst_nxt;
         baseSecond_r <= baseSecond_nxt;
         event_r      <= event_nxt;
         evMask_r     <= evMask_nxt;
         rstStat_r    <= rstStat_nxt;
         answer_r     <= answer_nxt;
         wakeReq_r    <= wakeReq_nxt;
         intReq_r     <= intReq_nxt;
      end
   end

endmodule : cfs_status_bank

// ---- cfs_pkg.sv ----
// shared constants and carrier types for the function status bank
package cfs_pkg;

   // ----------------------------------------------------------------
   // configuration space offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] CFG_BASE_FIRST_OFF  = 8'h14; // first base word
   localparam logic [7:0] CFG_BASE_SECOND_OFF = 8'h18; // second base word

   // ----------------------------------------------------------------
   // status window offsets and geometry
   // ----------------------------------------------------------------
   localparam logic [7:0] WIN_EVENT_OFF      = 8'h00; // event register
   localparam logic [7:0] WIN_EVENT_MASK_OFF = 8'h04; // event mask
   localparam logic [7:0] WIN_RESET_STAT_OFF = 8'h08; // reset status
   localparam int         BASE_LOW_BITS      = 8;     // low bits read 0
   localparam logic [23:0] BASE_RESET_VAL    = 24'h00_0000; // base field

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BIT_GEN_WAKE  = 4;  // general wake-up
   localparam int BIT_WAKE_MASK = 14; // wake-up mask
   localparam int BIT_INTR      = 15; // interrupt

   // ----------------------------------------------------------------
   // reset values and read masks
   // ----------------------------------------------------------------
   localparam logic [31:0] STAT_RESET_VAL  = 32'h0000_0000;
   localparam logic [31:0] EVENT_RD_MASK   = 32'h0000_8010; // 15 and 4
   localparam logic [31:0] MASK_RD_MASK    = 32'h0000_C010; // 15,14,4
   localparam logic [31:0] RESET_RD_MASK   = 32'h0000_8010; // 15 and 4

   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        isCfg;  // configuration space when set, else memory
      logic        wr;     // write strobe, one cycle
      logic        rd;     // read strobe, one cycle
      logic [31:0] addr;   // byte address
      logic [31:0] wdata;  // write data
      logic [3:0]  be;     // byte enables, active high
   } cfs_access_type;

   typedef struct packed {
      logic        valid;  // answer pulse
      logic        hit;    // access was claimed
      logic [31:0] rdata;  // read data, zero when not claimed
   } cfs_answer_type;

endpackage : cfs_pkg

// ---- cfs_sync2.sv ----
// two-stage synchroniser for a level arriving from a pin
`timescale 1ns/10ps
module cfs_sync2 (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic asyncIn,
   output logic      syncOut
);
   logic metaFlop_r; // first stage, read only by second stage
   logic metaFlop_nxt;
   logic syncOut_nxt;

   // next values: shift the level through
   always_comb begin
      metaFlop_nxt = asyncIn;
      syncOut_nxt  = metaFlop_r;
   end

   // register both stages
   always_ff @(posedge clk) begin
      if (rst) begin
         metaFlop_r <= 1'b0;
         syncOut    <= 1'b0;
      end else begin
         metaFlop_r <= metaFlop_nxt;
         syncOut    <= syncOut_nxt;
      end
   end
endmodule : cfs_sync2

// ---- cfs_status_bank_properties.sv ----
// concurrent checks on the function status bank ports
`timescale 1ns/10ps
module cfs_status_bank_properties (
   input wire logic                    clk,
   input wire logic                    rst,
   input wire logic                    cardModeIn,
   input wire cfs_pkg::cfs_access_type accessIn,
   input wire logic                    wakeEventIn,
   input wire logic                    intEventIn,
   input wire cfs_pkg::cfs_answer_type answer_r,
   input wire logic                    wakeReq_r,
   input wire logic                    intReq_r
);
   import cfs_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // step sequences
   // ------------------------------------------------------------
   sequence taken_s; accessIn.rd || accessIn.wr; endsequence
   sequence idle_s; !(accessIn.rd || accessIn.wr); endsequence
   sequence card_low_s; !cardModeIn [*4]; endsequence
   chk_answer_one_cycle: assert property (taken_s |=> answer_r.valid)
      else $error("answer missing one cycle after access");
   chk_answer_no_spur: assert property (idle_s |=> !answer_r.valid)
      else $error("answer without access");
   chk_card_low_miss: assert property (card_low_s ##0 taken_s |=> !answer_r.hit)
      else $error("claimed with card mode low");
   chk_window_rsvd_zero: assert property (answer_r.valid
      && !$past(accessIn.isCfg) |-> (answer_r.rdata & 32'hFFFF_3FEF) == 0)
      else $error("reserved window bits not zero");
   chk_base_low_zero: assert property (answer_r.valid && $past(accessIn.isCfg)
      |-> answer_r.rdata[7:0] == 8'h00) else $error("base low byte set");
   chk_miss_data_zero: assert property (answer_r.valid && !answer_r.hit
      |-> answer_r.rdata == 0) else $error("unclaimed access gave data");
   chk_write_data_zero: assert property (answer_r.valid && $past(accessIn.wr)
      |-> answer_r.rdata == 0) else $error("write answered with data");
   chk_int_req_cause: assert property ($rose(intReq_r)
      |-> $past(intEventIn, 2) || $past(accessIn.wr, 2))
      else $error("interrupt request without cause");
   chk_wake_req_cause: assert property ($rose(wakeReq_r)
      |-> $past(wakeEventIn, 2) || $past(accessIn.wr, 2))
      else $error("wake request without cause");
   cov_req: cover property (intReq_r && wakeReq_r);
endmodule : cfs_status_bank_properties
bind cfs_status_bank cfs_status_bank_properties chk_u (.clk(clk), .rst(rst),
   .cardModeIn(cardModeIn), .accessIn(accessIn), .wakeEventIn(wakeEventIn),
   .intEventIn(intEventIn), .answer_r(answer_r), .wakeReq_r(wakeReq_r),
   .intReq_r(intReq_r));

// ---- cfs_host_model.sv ----
// host bridge model issuing single-word register accesses
`timescale 1ns/10ps
module cfs_host_model (
   input  wire logic               clk,
   output cfs_pkg::cfs_access_type accessOut
);
   import cfs_pkg::*;
   initial accessOut = '0;
   // one access held across exactly one sampling edge
   task xfer(input logic c, input logic w, input logic [31:0] a,
             input logic [31:0] d, input logic [3:0] b);
      #1 accessOut = '{isCfg: c, wr: w, rd: !w, addr: a, wdata: d, be: b};
      @(posedge clk);
   endtask : xfer
   // released strobes drop to zero, other lines show inverted leftovers
   task idle;
      #1 accessOut = '{isCfg: !accessOut.isCfg, wr: 1'b0, rd: 1'b0,
         addr: ~accessOut.addr, wdata: ~accessOut.wdata, be: ~accessOut.be};
   endtask : idle
endmodule : cfs_host_model

// ---- cfs_status_bank_test.sv ----
// self-checking bench for the function status bank
`timescale 1ns/10ps
module cfs_status_bank_test;
   import cfs_pkg::*;
   logic           clk = 1'b0;    // 125 MHz
   logic           rst, cardModeIn, wakeEventIn, intEventIn;
   cfs_access_type accessIn;       // from host model
   cfs_answer_type answer_r;       // registered answer
   logic           wakeReq_r, intReq_r;
   logic [32:0]    expQ[$];        // expected {hit, rdata}
   logic [31:0]    w1, w2, rnd;    // window bases, random word
   integer         seed, mismatches, n_checks;
   always #4 clk = ~clk;
   cfs_host_model host_u (.clk(clk), .accessOut(accessIn));
   cfs_status_bank dut_u (.clk(clk), .rst(rst), .cardModeIn(cardModeIn),
      .accessIn(accessIn), .wakeEventIn(wakeEventIn),
      .intEventIn(intEventIn), .answer_r(answer_r),
      .wakeReq_r(wakeReq_r), .intReq_r(intReq_r));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task chk(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // note expectation, then issue access
   task acc(input logic c, input logic w, input logic [31:0] a,
            input logic [31:0] d, input logic [3:0] b, input logic [32:0] e);
      expQ.push_back(e);
      host_u.xfer(c, w, a, d, b);
   endtask : acc
   task end_sim;
      if (mismatches == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   // monitor: oldest note against each answer
   always @(posedge clk) begin
      #2;
      if (answer_r.valid === 1'b1) begin
         if (expQ.size() == 0) chk({answer_r.hit, answer_r.rdata}, 33'hx);
         else chk({answer_r.hit, answer_r.rdata}, expQ.pop_front());
      end
   end
   // watchdog
   initial begin
      #5000;
      mismatches++;
      end_sim();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      cardModeIn = 1'b0;
      wakeEventIn = 1'b0;
      intEventIn = 1'b0;
      seed = 32'hbf8e;
      mismatches = 0;
      n_checks = 0;
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk);
      acc(1, 0, 32'h0000_0014, 0, 4'hF, 33'h0_0000_0000);
      host_u.idle();
      cardModeIn = 1'b1;
      repeat (3) @(posedge clk);
      acc(1, 0, 32'h0000_0014, 0, 4'hF, 33'h1_0000_0000);
      w1 = ($random(seed) | 32'h0000_0100) & 32'hFFFF_FF00;
      w2 = ($random(seed) | 32'h0000_0200) & 32'hFFFF_FF00;
      acc(1, 1, 32'h0000_0014, w1 | 32'h0000_00FF, 4'hF, 33'h1_0000_0000);
      acc(1, 1, 32'h0000_0018, w2, 4'hF, 33'h1_0000_0000);
      acc(1, 0, 32'h0000_0014, 0, 4'hF, {1'b1, w1});
      acc(1, 0, 32'h0000_0018, 0, 4'hF, {1'b1, w2});
      acc(0, 1, w1 + 4, 32'hFFFF_FFFF, 4'hF, 33'h1_0000_0000);
      acc(0, 0, w2 + 4, 0, 4'hF, 33'h1_0000_C010);
      rnd = $random(seed);
      acc(0, 1, w1 + 8, rnd, 4'hF, 33'h1_0000_0000);
      acc(0, 0, w2 + 8, 0, 4'hF, {1'b1, rnd & 32'h0000_8010});
      acc(0, 0, w1, 0, 4'hF, 33'h1_0000_0000);
      host_u.idle();
      wakeEventIn = 1'b1;
      intEventIn = 1'b1;
      @(posedge clk);
      #1 wakeEventIn = 1'b0;
      intEventIn = 1'b0;
      repeat (2) @(posedge clk);
      #1 chk({31'h0, wakeReq_r, intReq_r}, 33'h3);
      @(posedge clk);
      acc(0, 0, w2, 0, 4'hF, 33'h1_0000_8010);
      acc(0, 1, w1 + 4, 0, 4'b0010, 33'h1_0000_0000);
      acc(0, 0, w1 + 4, 0, 4'hF, 33'h1_0000_0010);
      host_u.idle();
      #1 chk({31'h0, wakeReq_r, intReq_r}, 33'h0);
      @(posedge clk);
      acc(0, 1, w1, 32'h0000_8010, 4'hF, 33'h1_0000_0000);
      acc(0, 0, w1, 0, 4'hF, 33'h1_0000_0000);
      acc(0, 1, w1 + 12, 32'hFFFF_FFFF, 4'hF, 33'h1_0000_0000);
      acc(0, 0, w1 + 12, 0, 4'hF, 33'h1_0000_0000);
      acc(1, 0, 32'h0000_0010, 0, 4'hF, 33'h0_0000_0000);
      host_u.idle();
      cardModeIn = 1'b0;
      repeat (3) @(posedge clk);
      acc(1, 0, 32'h0000_0014, 0, 4'hF, 33'h0_0000_0000);
      host_u.idle();
      repeat (3) @(posedge clk);
      end_sim();
   end
endmodule : cfs_status_bank_test
